// >>> design/aas_defines.vh
/*
 constants for the address arithmetic slice: widths, the route line bit position,
 source and destination selections.
 assumes inclusion by bare name from the design files.
*/
`ifndef AAS_DEFINES_VH
`define AAS_DEFINES_VH

// ==========================================================
// widths
`define AAS_WIDTH 4
`define AAS_INSTR_W 4

// ==========================================================
// source operand select codes
`define AAS_SRC_R0 2'h0
`define AAS_SRC_R1 2'h1
`define AAS_SRC_R2 2'h2
`define AAS_SRC_NONE 2'h3

// ==========================================================
// destination register codes
`define AAS_DST_R0 2'h0
`define AAS_DST_R1 2'h1
`define AAS_DST_R2 2'h2

// ==========================================================
// instruction line bit positions
`define AAS_BIT_ROUTE 0

// ==========================================================
// reset values
`define AAS_REG_RESET 4'h0

`endif

// >>> design/aas_decode.v
/*
 instruction decoder: maps instruction lines three to one onto source and
 destination selections, and the register shown on the address bus.
 assumes purely combinational use inside the slice.
*/
`timescale 1ns/100ps
`include "aas_defines.vh"

module aas_decode (
    input wire [2:0] op_bits,
    output reg [1:0] src_sel,
    output reg [1:0] dst_sel,
    output reg [1:0] show_sel
);

    // ==========================================================
    // decode table
    // data-only codes still name a register to show when routing is low
    always @* begin
        case (op_bits)
            3'h0: begin
                src_sel = `AAS_SRC_R0; // [RQ1]
                dst_sel = `AAS_DST_R0;
                show_sel = `AAS_SRC_R0;
            end
            3'h1: begin
                src_sel = `AAS_SRC_R0; // [RQ2]
                dst_sel = `AAS_DST_R1;
                show_sel = `AAS_SRC_R0;
            end
            3'h2: begin
                src_sel = `AAS_SRC_R0; // [RQ3]
                dst_sel = `AAS_DST_R2;
                show_sel = `AAS_SRC_R0;
            end
            3'h3: begin
                src_sel = `AAS_SRC_R1; // [RQ4]
                dst_sel = `AAS_DST_R1;
                show_sel = `AAS_SRC_R1;
            end
            3'h4: begin
                src_sel = `AAS_SRC_NONE; // [RQ5]
                dst_sel = `AAS_DST_R2;
                show_sel = `AAS_SRC_R2;
            end
            3'h5: begin
                src_sel = `AAS_SRC_NONE; // [RQ6]
                dst_sel = `AAS_DST_R0;
                show_sel = `AAS_SRC_R0;
            end
            3'h6: begin
                src_sel = `AAS_SRC_R2; // [RQ7]
                dst_sel = `AAS_DST_R2;
                show_sel = `AAS_SRC_R2;
            end
            3'h7: begin
                src_sel = `AAS_SRC_NONE; // [RQ8]
                dst_sel = `AAS_DST_R1;
                show_sel = `AAS_SRC_R1;
            end
            default: begin
                src_sel = `AAS_SRC_R0;
                dst_sel = `AAS_DST_R0;
                show_sel = `AAS_SRC_R0;
            end
        endcase
    end

endmodule // aas_decode

// >>> design/aas_adder.v
/*
 ripple adder with active-low operand, carry-in and carry-out.
 assumes the operand and carries keep the low-active convention on pins.
*/
`timescale 1ns/100ps

module aas_adder #(
    parameter WIDTH = 4
) (
    input wire [WIDTH-1:0] reg_operand,
    input wire [WIDTH-1:0] data_operand_n,
    input wire carry_in_n,
    output wire [WIDTH-1:0] sum,
    output wire carry_out_n
);

    wire [WIDTH:0] full_sum;

    // ==========================================================
    // invert low-active terms, add, invert carry back for chaining
    assign full_sum = {1'b0, reg_operand} + {1'b0, ~data_operand_n} +
                      {{WIDTH{1'b0}}, ~carry_in_n}; // [RQ13]
    assign sum = full_sum[WIDTH-1:0];
    assign carry_out_n = ~full_sum[WIDTH]; // [RQ13]

endmodule // aas_adder

// >>> design/aas_slice.v
/*
 address arithmetic slice: three working registers, an adder, an output
 register, an address bus multiplexer and two enable-gated buses.
 assumes all control pins come from another clock domain or the board, so
 they pass two flip-flops; the pin clock is sampled and its rising edge,
 qualified by execute, forms the write strobe on the system clock.
 assumes the controller holds operands still for at least three system clocks
 around each pin clock edge, because every pin is seen three cycles late.
*/
//
// Operation
// [RQ1] codes 000: r0 plus data plus carry into r0 and output register
// [RQ2] codes 001: r0 plus data plus carry into r1 and output register
// [RQ3] codes 010: r0 plus data plus carry into r2 and output register
// [RQ4] codes 011: r1 plus data plus carry into r1 and output register
// [RQ5] codes 100: data plus carry into r2 and output register
// [RQ6] codes 101: data plus carry into r0 and output register
// [RQ7] codes 110: r2 plus data plus carry into r2 and output register
// [RQ8] codes 111: data plus carry into r1 and output register
// [RQ9] route line low shows listed register, high shows adder sum
// [RQ10] internal clock is pin clock OR execute_n
// [RQ11] write on rising clock only while execute_n low
// [RQ12] sum routing to address bus ignores clock and execute
// [RQ13] data, carry-in, carry-out active low; carries chain by ripple
// [RQ14] separate low enables gate address and result buses; data outputs low (only result_bus_out_n is low-active; address_bus_out is driven true)
`timescale 1ns/100ps
`include "aas_defines.vh"

module aas_slice #(
    parameter WIDTH = 4
) (
    input wire clk,
    input wire rst_n,
    input wire slice_clk,
    input wire execute_n,
    input wire [3:0] instr_lines,
    input wire [WIDTH-1:0] data_operand_n,
    input wire carry_in_n,
    input wire address_bus_enable_n,
    input wire result_bus_enable_n,
    output reg carry_out_n,
    output reg [WIDTH-1:0] address_bus_out,
    output reg address_bus_oe,
    output reg [WIDTH-1:0] result_bus_out_n,
    output reg result_bus_oe
);

    // ==========================================================
    // input synchronisers (first stage read only by the second)
    reg slice_clk_s1_r;
    reg slice_clk_s2_r;
    reg execute_n_s1_r;
    reg execute_n_s2_r;
    reg [3:0] instr_s1_r;
    reg [3:0] instr_s2_r;
    reg [WIDTH-1:0] data_s1_r;
    reg [WIDTH-1:0] data_s2_r;
    reg carry_s1_r;
    reg carry_s2_r;
    reg aen_s1_r;
    reg aen_s2_r;
    reg ren_s1_r;
    reg ren_s2_r;

    // pin clock; its reset level is harmless because execute resets inactive
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slice_clk_s1_r <= 1'b0;
            slice_clk_s2_r <= 1'b0;
        end else begin
            slice_clk_s1_r <= slice_clk;
            slice_clk_s2_r <= slice_clk_s1_r;
        end
    end

    // execute resets inactive so no write can follow reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            execute_n_s1_r <= 1'b1;
            execute_n_s2_r <= 1'b1;
        end else begin
            execute_n_s1_r <= execute_n;
            execute_n_s2_r <= execute_n_s1_r;
        end
    end

    // instruction lines, route select included
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_s1_r <= 4'h0;
            instr_s2_r <= 4'h0;
        end else begin
            instr_s1_r <= instr_lines;
            instr_s2_r <= instr_s1_r;
        end
    end

    // data operand rests at its inactive high level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_s1_r <= {WIDTH{1'b1}};
            data_s2_r <= {WIDTH{1'b1}};
        end else begin
            data_s1_r <= data_operand_n;
            data_s2_r <= data_s1_r;
        end
    end

    // carry-in rests at its inactive high level
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_s1_r <= 1'b1;
            carry_s2_r <= 1'b1;
        end else begin
            carry_s1_r <= carry_in_n;
            carry_s2_r <= carry_s1_r;
        end
    end

    // address bus enable resets high so the bus stays released in reset
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aen_s1_r <= 1'b1;
            aen_s2_r <= 1'b1;
        end else begin
            aen_s1_r <= address_bus_enable_n;
            aen_s2_r <= aen_s1_r;
        end
    end

    // result bus enable resets high for the same reason
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ren_s1_r <= 1'b1;
            ren_s2_r <= 1'b1;
        end else begin
            ren_s1_r <= result_bus_enable_n;
            ren_s2_r <= ren_s1_r;
        end
    end

    // ==========================================================
    // internal clock and write strobe
    // the write strobe fires only when the internal clock rises with execute low,
    // so a rise caused by execute going high is excluded from writing
    wire internal_clk;
    wire write_stb;
    reg internal_clk_d_r;
    assign internal_clk = slice_clk_s2_r | execute_n_s2_r; // [RQ10]

    // history of the internal clock; resets to its idle high level so the
    // edge detector cannot see a false rise as reset ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            internal_clk_d_r <= 1'b1;
        end else begin
            internal_clk_d_r <= internal_clk;
        end
    end

    assign write_stb = internal_clk & ~internal_clk_d_r & ~execute_n_s2_r; // [RQ11]

    // ==========================================================
    // decode and operand select
    wire [1:0] src_sel;
    wire [1:0] dst_sel;
    wire [1:0] show_sel;
    wire [2:0] op_bits;
    wire bus_route_select;
    assign op_bits = instr_s2_r[3:1];
    assign bus_route_select = instr_s2_r[`AAS_BIT_ROUTE];

    aas_decode u_decode (
        .op_bits(op_bits),
        .src_sel(src_sel),
        .dst_sel(dst_sel),
        .show_sel(show_sel)
    );

    reg [WIDTH-1:0] work_reg_zero_r;
    reg [WIDTH-1:0] work_reg_one_r;
    reg [WIDTH-1:0] work_reg_two_r;
    reg [WIDTH-1:0] output_reg_r;
    reg [WIDTH-1:0] reg_operand;
    reg [WIDTH-1:0] shown_reg;

    // operand mux; data-only codes feed zero into the adder
    always @* begin
        case (src_sel)
            `AAS_SRC_R0: reg_operand = work_reg_zero_r;
            `AAS_SRC_R1: reg_operand = work_reg_one_r;
            `AAS_SRC_R2: reg_operand = work_reg_two_r;
            default: reg_operand = {WIDTH{1'b0}}; // [RQ5] [RQ6] [RQ8]
        endcase
    end

    // register shown on the address bus when routing line is low
    always @* begin
        case (show_sel)
            `AAS_SRC_R1: shown_reg = work_reg_one_r;
            `AAS_SRC_R2: shown_reg = work_reg_two_r;
            default: shown_reg = work_reg_zero_r;
        endcase
    end

    // ==========================================================
    // adder
    // a chained slice sees this carry three cycles late, so a wide word
    // needs its operands held longer for every slice in the chain
    wire [WIDTH-1:0] sum;
    wire sum_carry_n;

    aas_adder #(
        .WIDTH(WIDTH)
    ) u_adder (
        .reg_operand(reg_operand),
        .data_operand_n(data_s2_r),
        .carry_in_n(carry_s2_r),
        .sum(sum),
        .carry_out_n(sum_carry_n)
    );

    // ==========================================================
    // register writes on the qualified rising edge
    // one enable per destination keeps each register's hold path obvious
    wire wr_zero;
    wire wr_one;
    wire wr_two;
    assign wr_zero = write_stb & (dst_sel == `AAS_DST_R0); // [RQ1] [RQ6]
    assign wr_one = write_stb & (dst_sel == `AAS_DST_R1); // [RQ2] [RQ4] [RQ8]
    assign wr_two = write_stb & (dst_sel == `AAS_DST_R2); // [RQ3] [RQ5] [RQ7]

    // output register takes every result, whatever the destination
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            output_reg_r <= `AAS_REG_RESET;
        end else if (write_stb) begin // [RQ11]
            output_reg_r <= sum; // [RQ1] [RQ2] [RQ3] [RQ4] [RQ5] [RQ6] [RQ7] [RQ8]
        end
    end

    // working register zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg_zero_r <= `AAS_REG_RESET;
        end else if (wr_zero) begin
            work_reg_zero_r <= sum; // [RQ1] [RQ6]
        end
    end

    // working register one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg_one_r <= `AAS_REG_RESET;
        end else if (wr_one) begin
            work_reg_one_r <= sum; // [RQ2] [RQ4] [RQ8]
        end
    end

    // working register two
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            work_reg_two_r <= `AAS_REG_RESET;
        end else if (wr_two) begin
            work_reg_two_r <= sum; // [RQ3] [RQ5] [RQ7]
        end
    end

    // ==========================================================
    // outputs, registered so every port comes from a flip-flop

    // the route mux follows the sampled inputs every cycle, never the strobe,
    // so a changed sum shows even while execute is high
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            address_bus_out <= {WIDTH{1'b0}};
        end else begin
            address_bus_out <= bus_route_select ? sum : shown_reg; // [RQ9] [RQ12]
        end
    end

    // bus enables, high while the slice drives the bus
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            address_bus_oe <= 1'b0;
            result_bus_oe <= 1'b0;
        end else begin
            address_bus_oe <= ~aen_s2_r; // [RQ14]
            result_bus_oe <= ~ren_s2_r; // [RQ14]
        end
    end

    // result bus shows the output register in its low-active form
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_bus_out_n <= {WIDTH{1'b1}};
        end else begin
            result_bus_out_n <= ~output_reg_r; // [RQ14]
        end
    end

    // carry out follows the adder of the current inputs
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            carry_out_n <= 1'b1;
        end else begin
            carry_out_n <= sum_carry_n; // [RQ13]
        end
    end

endmodule // aas_slice

// >>> testbench/aas_slice_props.sv
/* pin checker for the address arithmetic slice.
   assumes a bind onto aas_slice from the bench top file. */
`timescale 1ns/100ps
module aas_slice_props #(parameter WIDTH = 4) (
    input wire clk,
    input wire rst_n,
    input wire slice_clk,
    input wire execute_n,
    input wire [3:0] instr_lines,
    input wire [WIDTH-1:0] data_operand_n,
    input wire carry_in_n,
    input wire address_bus_enable_n,
    input wire result_bus_enable_n,
    input wire carry_out_n,
    input wire [WIDTH-1:0] address_bus_out,
    input wire address_bus_oe,
    input wire [WIDTH-1:0] result_bus_out_n,
    input wire result_bus_oe
);
// ==========================================================
// helpers: data-only sum, pins active low
wire [WIDTH:0] dsum = {1'b0, ~data_operand_n} + {{WIDTH{1'b0}}, ~carry_in_n};
wire donly = instr_lines[0] && (instr_lines[3:1] == 3'h4 || instr_lines[3:1] == 3'h5 ||
    instr_lines[3:1] == 3'h7);
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);
// ==========================================================
// stable windows leave room for the three-cycle pin latency
AST_ADDR_OE: assert property ($stable(address_bus_enable_n) [*5] |->
    address_bus_oe == !address_bus_enable_n) else $error("address enable wrong");
AST_RES_OE: assert property ($stable(result_bus_enable_n) [*5] |->
    result_bus_oe == !result_bus_enable_n) else $error("result enable wrong");
AST_RESET_IDLE: assert property (disable iff (1'b0) !rst_n |->
    !address_bus_oe && !result_bus_oe) else $error("bus driven in reset");
AST_RES_HOLD: assert property ($stable(slice_clk) [*8] |->
    $stable(result_bus_out_n)) else $error("result moved without clock");
AST_NO_EXEC: assert property (execute_n [*8] |->
    $stable(result_bus_out_n)) else $error("write without execute");
AST_ADDR_QUIET: assert property (($stable(instr_lines) && $stable(data_operand_n) &&
    $stable(carry_in_n) && execute_n) [*8] |-> $stable(address_bus_out))
    else $error("address moved with quiet inputs");
AST_DATA_SUM: assert property (($stable(instr_lines) && $stable(data_operand_n) &&
    $stable(carry_in_n) && donly) [*6] |-> address_bus_out == dsum[WIDTH-1:0])
    else $error("data-only sum wrong");
AST_DATA_CARRY: assert property (($stable(instr_lines) && $stable(data_operand_n) &&
    $stable(carry_in_n) && donly) [*6] |-> carry_out_n == !dsum[WIDTH])
    else $error("data-only carry wrong");
endmodule // aas_slice_props

// >>> testbench/aas_ctrl_model.sv
/* microprogram controller model driving one slice microcycle per request.
   assumes requests are held until busy is seen. */
`timescale 1ns/100ps
module aas_ctrl_model (
    input wire clk,
    input wire req,
    input wire [3:0] op,
    input wire [3:0] d_n,
    input wire ci_n,
    input wire ex_n,
    output reg busy,
    output reg slice_clk,
    output reg execute_n,
    output reg [3:0] instr_lines,
    output reg [3:0] data_operand_n,
    output reg carry_in_n
);
// ==========================================================
// pin clock idles high so the internal clock never rises between cycles
initial begin
    busy = 0;
    slice_clk = 1;
    execute_n = 1;
    instr_lines = 4'h0;
    data_operand_n = 4'hf;
    carry_in_n = 1;
    forever begin
        @(posedge clk);
        if (req && !busy) begin
            busy <= 1;
            instr_lines <= op;
            data_operand_n <= d_n;
            carry_in_n <= ci_n;
            execute_n <= ex_n;
            repeat (4) @(posedge clk);
            slice_clk <= 0;
            repeat (4) @(posedge clk);
            slice_clk <= 1;
            repeat (4) @(posedge clk);
            execute_n <= 1;
            busy <= 0;
        end
    end
end
endmodule // aas_ctrl_model

// >>> testbench/address_arithmetic_slice_bench.sv
/* self-checking bench: random microcycles against an integer model.
   assumes the controller model drives the pin clock and operands. */
`timescale 1ns/100ps
module address_arithmetic_slice_bench;
localparam [15:0] SRC = {2'h3, 2'h2, 2'h3, 2'h3, 2'h1, 2'h0, 2'h0, 2'h0};
localparam [15:0] DST = {2'h1, 2'h2, 2'h0, 2'h2, 2'h1, 2'h2, 2'h1, 2'h0};
reg clk, rst_n, req, ex_n, ci_n, aen_n, ren_n;
reg [3:0] op, d_n;
reg [3:0] exp_ab;
reg [31:0] rs;
wire busy, sclk, exn, cin, co_n, aoe, roe;
wire [3:0] il, dn, ab, rb_n;
integer err_total, checks, i, k, s, sum, oreg;
integer r [0:2];
aas_ctrl_model u_aas_ctrl_model (.clk(clk), .req(req), .op(op), .d_n(d_n), .ci_n(ci_n),
    .ex_n(ex_n), .busy(busy), .slice_clk(sclk), .execute_n(exn), .instr_lines(il),
    .data_operand_n(dn), .carry_in_n(cin));
aas_slice #(.WIDTH(4)) u_aas_slice (.clk(clk), .rst_n(rst_n), .slice_clk(sclk),
    .execute_n(exn), .instr_lines(il), .data_operand_n(dn), .carry_in_n(cin),
    .address_bus_enable_n(aen_n), .result_bus_enable_n(ren_n), .carry_out_n(co_n),
    .address_bus_out(ab), .address_bus_oe(aoe), .result_bus_out_n(rb_n), .result_bus_oe(roe));
// ==========================================================
// helpers
function [31:0] xs(input [31:0] v);
    reg [31:0] t;
    begin
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    end
endfunction
// adder model: register term (or none) plus inverted pins
function integer addv(input integer kk);
    integer q;
    begin
        q = SRC[kk*2+:2];
        addv = (q == 3 ? 0 : r[q]) + 15 - d_n + 1 - ci_n;
    end
endfunction
task chk(input [3:0] got, input [3:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
endtask
task test_done;
    begin
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
endtask
// ==========================================================
// clock, watchdog, main sequence
initial begin
    clk = 0;
    forever #5 clk = ~clk;
end
initial begin
    repeat (5000) @(posedge clk);
    err_total = err_total + 1;
    test_done;
end
initial begin
    rst_n = 0;
    req = 0;
    op = 4'h0;
    d_n = 4'hf;
    ci_n = 1;
    ex_n = 1;
    aen_n = 0;
    ren_n = 0;
    rs = 32'hdadd;
    err_total = 0;
    checks = 0;
    oreg = 0;
    r[0] = 0;
    r[1] = 0;
    r[2] = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
    chk(rb_n, 4'hf);
    // first sixteen walk every code with execute low, the rest are random;
    // one of them is always run without execute so a refused write is seen
    for (i = 0; i < 60; i = i + 1) begin
        rs = xs(rs);
        op <= (i < 16) ? i[3:0] : rs[3:0];
        d_n <= rs[7:4];
        ci_n <= rs[8];
        ex_n <= (i == 20) || ((i >= 16) && (rs[11:9] == 3'h0));
        aen_n <= rs[12];
        ren_n <= rs[13];
        req <= 1;
        @(posedge clk);
        while (!busy) @(posedge clk);
        req <= 0;
        while (busy) @(posedge clk);
        repeat (6) @(posedge clk);
        k = op[3:1];
        if (!ex_n) begin
            sum = addv(k) % 16;
            r[DST[k*2+:2]] = sum;
            oreg = sum;
        end
        sum = addv(k);
        s = (SRC[k*2+:2] == 3) ? DST[k*2+:2] : SRC[k*2+:2];
        exp_ab = op[0] ? sum[3:0] : r[s][3:0];
        chk(ab, exp_ab);
        chk(rb_n, ~oreg[3:0]);
        chk({3'h0, co_n}, {3'h0, ~sum[4]});
        chk({2'h0, aoe, roe}, {2'h0, ~aen_n, ~ren_n});
    end
    test_done;
end
endmodule // address_arithmetic_slice_bench
bind aas_slice aas_slice_props #(.WIDTH(WIDTH)) u_aas_slice_props (.clk(clk), .rst_n(rst_n),
    .slice_clk(slice_clk), .execute_n(execute_n), .instr_lines(instr_lines),
    .data_operand_n(data_operand_n), .carry_in_n(carry_in_n),
    .address_bus_enable_n(address_bus_enable_n), .result_bus_enable_n(result_bus_enable_n),
    .carry_out_n(carry_out_n), .address_bus_out(address_bus_out),
    .address_bus_oe(address_bus_oe), .result_bus_out_n(result_bus_out_n),
    .result_bus_oe(result_bus_oe));
